// *** hw/pf_defs.svh ***
/*
 * Constants for the programmable FIR equaliser: register offsets, reset
 * values, widths and tap geometry.
 * Assumes it is included by bare name from files that need these values.
 */
`ifndef PF_DEFS_SVH
`define PF_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PF_ADDR_W       12
`define PF_DATA_W       16
`define PF_ADDR_CFG     12'h400
`define PF_ADDR_A0      12'h418
`define PF_ADDR_A1      12'h41A
`define PF_CFG_RST      8'h00
`define PF_COEF_RST     16'h0000
`define PF_RD_ZERO      16'h0000
`define PF_CFG_W        8
`define PF_CFG_PAD      8'h00
`define PF_COEF_RSV_MSB 15
`define PF_COEF_RSV_LSB 12

// ****************************************************************
// Datapath geometry
// ****************************************************************
`define PF_NTAPS        9
`define PF_CTR_TAP      4
`define PF_TAP_A0       0
`define PF_TAP_A1       1
`define PF_SAMP_W       12
`define PF_COEF_W       12
`define PF_COEF_MSB     11
`define PF_CTR_W        18
`define PF_ACC_W        36
`define PF_FRAC_BITS    16
`define PF_CTR_UNITY    18'h10000
`define PF_SAMP_MAX     36'sh0000007FF
`define PF_SAMP_MIN     -36'sh000000800

`endif

// *** hw/pf_fir_mac.sv ***
/*
 * Nine-tap multiply-accumulate for one output sample, purely combinational.
 * Assumes the caller registers the result and holds the window stable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pf_defs.svh"

module pf_fir_mac
    import pf_pkg::*;
(
    input  wire pf_win_t                win_i,
    input  wire pf_coefs_t              coef_i,
    input  wire logic [`PF_CTR_W-1:0]   ctr_coef_i,
    input  wire logic [2:0]             weight_i,
    output logic [`PF_SAMP_W-1:0]       y_o
);

    logic signed [`PF_ACC_W-1:0] term [`PF_NTAPS];
    logic signed [`PF_ACC_W-1:0] acc;
    logic signed [`PF_ACC_W-1:0] scaled;

    // ****************************************************************
    // Per-tap products
    // ****************************************************************
    genvar k;
    for (k = 0; k < `PF_NTAPS; k++) begin : g_tap
        if (k == `PF_CTR_TAP) begin : g_ctr
            // Centre tap is full 18 bit and ignores the side weight
            assign term[k] = `PF_ACC_W'($signed(win_i[k]) * $signed(ctr_coef_i));
        end else begin : g_side
            assign term[k] = `PF_ACC_W'($signed(win_i[k]) * $signed(coef_i[k]))
                             <<< weight_i;
        end
    end

    // ****************************************************************
    // Sum, drop fraction, saturate
    // ****************************************************************
    always_comb begin
        acc = '0;
        for (int i = 0; i < `PF_NTAPS; i++) begin
            acc = acc + term[i];
        end
        // All taps share an LSB of 2^-16 once side terms are shifted
        scaled = acc >>> `PF_FRAC_BITS;
        if (scaled > `PF_SAMP_MAX) begin
            y_o = `PF_SAMP_W'(`PF_SAMP_MAX);
        end else if (scaled < `PF_SAMP_MIN) begin
            y_o = `PF_SAMP_W'(`PF_SAMP_MIN);
        end else begin
            y_o = scaled[`PF_SAMP_W-1:0];
        end
    end

endmodule

`default_nettype wire

// *** hw/pf_pkg.sv ***
/*
 * Types for the programmable FIR equaliser: mode enumeration, the
 * configuration register layout and the sample and register carriers.
 * Assumes pf_defs.svh sits on the include path.
 */
`include "pf_defs.svh"

package pf_pkg;

    typedef enum logic [1:0] {
        PF_MODE_OFF  = 2'h0,
        PF_MODE_RSV1 = 2'h1,
        PF_MODE_ON   = 2'h2,
        PF_MODE_RSV3 = 2'h3
    } pf_mode_t;

    // Bit order gives 7 reserved, 6 share, 5 merge, 4:2 weight, 1:0 mode
    typedef struct packed {
        logic       rsvd;
        logic       coef_share_flag;
        logic       filter_merge_flag;
        logic [2:0] side_coef_weight;
        pf_mode_t   filter_mode_field;
    } pf_cfg_t;

    typedef struct packed {
        logic                   valid;
        logic [`PF_SAMP_W-1:0]  a;
        logic [`PF_SAMP_W-1:0]  b;
    } pf_samp_t;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`PF_ADDR_W-1:0]  addr;
        logic [`PF_DATA_W-1:0]  wdata;
    } pf_reg_req_t;

    typedef logic [`PF_NTAPS-1:0][`PF_SAMP_W-1:0] pf_win_t;
    typedef logic [`PF_NTAPS-1:0][`PF_COEF_W-1:0] pf_coefs_t;

endpackage

// *** hw/pf_prog_fir.sv ***
/*
 * Programmable FIR equaliser between the converter cores and the serial
 * transmit link, with its configuration and first two coefficient registers.
 * Assumes samples and register accesses arrive on clk_sys_i, and that
 * software reprograms only while the serial link is disabled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pf_defs.svh"

module pf_prog_fir
    import pf_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_i,
    input  wire pf_reg_req_t            reg_req_i,
    output logic [`PF_DATA_W-1:0]       reg_rdata_o,
    output logic                        reg_rvalid_o,
    input  wire pf_coefs_t              chan_b_coef_i,
    input  wire pf_samp_t               samp_i,
    output pf_samp_t                    samp_o,
    output logic                        filter_active_o
);

    pf_cfg_t                    cfg_q;
    logic [`PF_DATA_W-1:0]      a0_q;
    logic [`PF_DATA_W-1:0]      a1_q;
    pf_win_t                    hist_a_q;
    pf_win_t                    hist_b_q;
    logic                       valid_q;
    logic                       enabled;
    pf_win_t                    win_a;
    pf_win_t                    win_b;
    pf_coefs_t                  coef_a;
    pf_coefs_t                  coef_b;
    logic [`PF_SAMP_W-1:0]      y_a;
    logic [`PF_SAMP_W-1:0]      y_b;
    logic                       cfg_wr;
    logic                       a0_wr;
    logic                       a1_wr;
    logic [`PF_DATA_W-1:0]      a0_rd;
    logic [`PF_DATA_W-1:0]      a1_rd;
    logic [`PF_DATA_W-1:0]      rd_mux;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Exact compare on every address bit, so no mapped word has aliases
    assign cfg_wr = reg_req_i.wr && (reg_req_i.addr == `PF_ADDR_CFG);
    assign a0_wr  = reg_req_i.wr && (reg_req_i.addr == `PF_ADDR_A0);
    assign a1_wr  = reg_req_i.wr && (reg_req_i.addr == `PF_ADDR_A1);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // No shadow copy: writes land at once, hence link must be idle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg_q <= pf_cfg_t'(`PF_CFG_RST);
        end else if (cfg_wr) begin
            cfg_q <= pf_cfg_t'(reg_req_i.wdata[`PF_CFG_W-1:0]);
        end
    end

    // Full word kept, reserved nibble included
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            a0_q <= `PF_COEF_RST;
        end else if (a0_wr) begin
            a0_q <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            a1_q <= `PF_COEF_RST;
        end else if (a1_wr) begin
            a1_q <= reg_req_i.wdata;
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Top coefficient bit reads as zero; the filter still uses it
    assign a0_rd = {a0_q[`PF_COEF_RSV_MSB:`PF_COEF_RSV_LSB], 1'b0,
                    a0_q[`PF_COEF_MSB-1:0]};
    assign a1_rd = {a1_q[`PF_COEF_RSV_MSB:`PF_COEF_RSV_LSB], 1'b0,
                    a1_q[`PF_COEF_MSB-1:0]};

    always_comb begin
        case (reg_req_i.addr)
            `PF_ADDR_CFG: begin
                rd_mux = {`PF_CFG_PAD, cfg_q};
            end
            `PF_ADDR_A0: begin
                rd_mux = a0_rd;
            end
            `PF_ADDR_A1: begin
                rd_mux = a1_rd;
            end
            default: begin
                rd_mux = `PF_RD_ZERO;
            end
        endcase
    end

    // Data holds until the next read strobe
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= `PF_RD_ZERO;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    // Reserved mode codes are treated as off rather than trusted
    assign enabled = (cfg_q.filter_mode_field == PF_MODE_ON);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            filter_active_o <= 1'b0;
        end else begin
            filter_active_o <= enabled;
        end
    end

    // ****************************************************************
    // Sample history, index 0 newest
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hist_a_q <= '0;
            hist_b_q <= '0;
        end else if (samp_i.valid) begin
            hist_a_q <= {hist_a_q[`PF_NTAPS-2:0], samp_i.a};
            hist_b_q <= {hist_b_q[`PF_NTAPS-2:0], samp_i.b};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= samp_i.valid;
        end
    end

    // ****************************************************************
    // Tap windows and coefficient sets
    // ****************************************************************
    // Merged stream takes A as the earlier half of each sample pair
    genvar k;
    for (k = 0; k < `PF_NTAPS; k++) begin : g_win
        if (k % 2 == 0) begin : g_even
            assign win_a[k] = cfg_q.filter_merge_flag ? hist_a_q[k/2] : hist_a_q[k];
            assign win_b[k] = cfg_q.filter_merge_flag ? hist_b_q[k/2] : hist_b_q[k];
        end else begin : g_odd
            assign win_a[k] = cfg_q.filter_merge_flag ? hist_b_q[(k+1)/2] : hist_a_q[k];
            assign win_b[k] = cfg_q.filter_merge_flag ? hist_a_q[(k-1)/2] : hist_b_q[k];
        end
        // Taps past the second have no register here and stay zero, except the centre tap, which the MAC fixes at unity
        if (k == `PF_TAP_A0) begin : g_c0
            assign coef_a[k] = a0_q[`PF_COEF_MSB:0];
        end else if (k == `PF_TAP_A1) begin : g_c1
            assign coef_a[k] = a1_q[`PF_COEF_MSB:0];
        end else begin : g_cz
            assign coef_a[k] = '0;
        end
        // Merge also forces the single A set, as one filter needs one set
        assign coef_b[k] = (cfg_q.coef_share_flag || cfg_q.filter_merge_flag) ?
                           coef_a[k] : chan_b_coef_i[k];
    end

    // ****************************************************************
    // Filter arithmetic
    // ****************************************************************
    pf_fir_mac u_mac_a (
        .win_i      (win_a),
        .coef_i     (coef_a),
        .ctr_coef_i (`PF_CTR_UNITY),
        .weight_i   (cfg_q.side_coef_weight),
        .y_o        (y_a)
    );

    pf_fir_mac u_mac_b (
        .win_i      (win_b),
        .coef_i     (coef_b),
        .ctr_coef_i (`PF_CTR_UNITY),
        .weight_i   (cfg_q.side_coef_weight),
        .y_o        (y_b)
    );

    // ****************************************************************
    // Output stage
    // ****************************************************************
    // Bypass keeps the same two-cycle latency so enabling shifts no data
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            samp_o <= '0;
        end else begin
            samp_o.valid <= valid_q;
            if (valid_q) begin
                samp_o.a <= enabled ? y_a : hist_a_q[0];
                samp_o.b <= enabled ? y_b : hist_b_q[0];
            end
        end
    end

endmodule

`default_nettype wire

// *** tb/pf_adc_link_model.sv ***
/* Converter core source and serial link sink around the equaliser.
 * Assumes the bench calls send once per cycle and reads the queues. */
`timescale 1ns/1ps
`default_nettype none

module pf_adc_link_model
    import pf_pkg::*;
(
    input  wire logic     clk_sys_i,
    input  wire pf_samp_t samp_i,
    output var pf_samp_t  samp_o
);
    logic [11:0] qa[$];
    logic [11:0] qb[$];

    initial samp_o = '0;
    // Idle data lines flip so stale values are never mistaken for samples
    task automatic send(input logic v, input logic [11:0] a, input logic [11:0] b);
        @(posedge clk_sys_i);
        samp_o <= v ? {1'b1, a, b} : {1'b0, ~samp_o.a, ~samp_o.b};
    endtask
    // Link never stalls
    always @(posedge clk_sys_i) begin
        if (samp_i.valid === 1'b1) begin
            qa.push_back(samp_i.a);
            qb.push_back(samp_i.b);
        end
    end
endmodule
`default_nettype wire

// *** tb/pf_prog_fir_properties.sv ***
/* Port assertions for the FIR equaliser, bound into pf_prog_fir.
 * Assumes one clock, clk_sys_i, and a synchronous active-high reset_i. */
`timescale 1ns/1ps
`default_nettype none
`include "pf_defs.svh"

module pf_chk
    import pf_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire pf_reg_req_t reg_req_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic        reg_rvalid_o,
    input  wire pf_samp_t    samp_i,
    input  wire pf_samp_t    samp_o,
    input  wire logic        filter_active_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire cfg_wr = reg_req_i.wr && reg_req_i.addr == `PF_ADDR_CFG;
    wire cfg_rd = reg_req_i.rd && reg_req_i.addr == `PF_ADDR_CFG;

    sequence s_coef_rd;
        reg_req_i.rd && (reg_req_i.addr == `PF_ADDR_A0 || reg_req_i.addr == `PF_ADDR_A1);
    endsequence
    // Idle around the sample so a late mode change cannot mask it
    sequence s_off_pass;
        !filter_active_o ##1 (samp_i.valid && !filter_active_o) ##1 !filter_active_o [*2];
    endsequence

    property p_coef_msb;
        s_coef_rd |=> reg_rvalid_o && !reg_rdata_o[`PF_COEF_MSB];
    endproperty
    a_coef_msb: assert property (p_coef_msb)
        else $error("coef readback top bit set");
    property p_cfg_rd;
        cfg_rd |=> reg_rvalid_o && reg_rdata_o[15:8] == 8'h00;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("config readback upper byte set");
    property p_unmapped;
        reg_req_i.rd && !(reg_req_i.addr inside {`PF_ADDR_CFG, `PF_ADDR_A0, `PF_ADDR_A1})
            |=> reg_rvalid_o && reg_rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_quiet;
        !reg_req_i.rd |=> !reg_rvalid_o;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read valid without read");
    property p_lat;
        samp_i.valid |-> ##2 samp_o.valid;
    endproperty
    a_lat: assert property (p_lat)
        else $error("sample lost");
    property p_no_extra;
        !samp_i.valid |-> ##2 !samp_o.valid;
    endproperty
    a_no_extra: assert property (p_no_extra)
        else $error("spurious output sample");
    property p_bypass;
        s_off_pass |-> samp_o.valid && samp_o.a == $past(samp_i.a, 2)
            && samp_o.b == $past(samp_i.b, 2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass altered sample");
    property p_on;
        cfg_wr && reg_req_i.wdata[1:0] == 2'h2 |-> ##[1:2] filter_active_o;
    endproperty
    a_on: assert property (p_on)
        else $error("filter not enabled");
    property p_off;
        cfg_wr && reg_req_i.wdata[1:0] != 2'h2 |-> ##[1:2] !filter_active_o;
    endproperty
    a_off: assert property (p_off)
        else $error("filter not disabled");
    property p_reset;
        disable iff (1'b0) reset_i |=> !samp_o.valid && !reg_rvalid_o && !filter_active_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
endmodule

bind pf_prog_fir pf_chk u_chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .samp_i(samp_i),
    .samp_o(samp_o), .filter_active_o(filter_active_o)
);
`default_nettype wire

// *** tb/tb_pf_prog_fir.sv ***
/* Self-checking bench for pf_prog_fir: registers, modes and filter paths.
 * Assumes pf_adc_link_model sources and sinks the sample stream. */
`timescale 1ns/1ps
`default_nettype none
`include "pf_defs.svh"

module tb_pf_prog_fir
    import pf_pkg::*;
;
    logic        clk_sys_i;
    logic        reset_i;
    pf_reg_req_t req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        active;
    pf_coefs_t   b_coef;
    pf_samp_t    s_in;
    pf_samp_t    s_out;
    logic        serial_link_enable;
    int          n_mismatch;
    int          total_checks;

    pf_prog_fir dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .chan_b_coef_i(b_coef),
        .samp_i(s_in), .samp_o(s_out), .filter_active_o(active));
    pf_adc_link_model dm (.clk_sys_i(clk_sys_i), .samp_i(s_out), .samp_o(s_in));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        check({15'h0000, serial_link_enable}, 16'h0000);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            if (rvalid === 1'b1) begin
                check(rdata, exp);
                return;
            end
        end
        n_mismatch++;
        final_report();
    endtask
    // Impulse after a zero flush; six outputs per channel, first in the top bits
    task automatic flt(input logic [7:0] cfg, input logic [11:0] a, input logic [11:0] b,
                       input logic [71:0] ea, input logic [71:0] eb);
        serial_link_enable = 1'b0;
        wr(`PF_ADDR_CFG, {8'h00, cfg});
        serial_link_enable = 1'b1;
        repeat (9) dm.send(1'b1, 12'h000, 12'h000);
        dm.send(1'b0, 12'h000, 12'h000);
        repeat (5) @(posedge clk_sys_i);
        dm.qa.delete();
        dm.qb.delete();
        dm.send(1'b1, a, b);
        repeat (5) dm.send(1'b1, 12'h000, 12'h000);
        dm.send(1'b0, 12'h000, 12'h000);
        repeat (5) @(posedge clk_sys_i);
        check(16'(dm.qa.size()), 16'h0006);
        for (int i = 0; i < 6; i++) begin
            check({4'h0, dm.qa[i]}, {4'h0, ea[71-12*i -: 12]});
            check({4'h0, dm.qb[i]}, {4'h0, eb[71-12*i -: 12]});
        end
        serial_link_enable = 1'b0;
        $display("filter test done cfg=%h", cfg);
    endtask

    initial begin
        reset_i = 1'b1;
        req = '0;
        b_coef = '0;
        b_coef[0] = 12'h100;
        serial_link_enable = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rc(`PF_ADDR_CFG, 16'h0000);
        rc(`PF_ADDR_A0, 16'h0000);
        rc(`PF_ADDR_A1, 16'h0000);
        wr(`PF_ADDR_CFG, 16'h12A8);
        rc(`PF_ADDR_CFG, 16'h00A8);
        wr(`PF_ADDR_A0, 16'hF800);
        rc(`PF_ADDR_A0, 16'hF000);
        rc(12'h402, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            // Reserved codes stay unwritten, as the host must avoid them
            wr(`PF_ADDR_CFG, 16'(2 * (m % 2)));
            repeat (2) @(posedge clk_sys_i);
            check({15'h0000, active}, {15'h0000, (m % 2) == 1});
        end
        $display("register test done");
        wr(`PF_ADDR_A0, 16'h0400);
        wr(`PF_ADDR_A1, 16'h0200);
        flt(8'h00, 12'h123, 12'h456, 72'h123000000000000000, 72'h456000000000000000);
        flt(8'h1A, 12'h010, 12'h010, 72'h010008000000010000, 72'h004000000000010000);
        flt(8'h5A, 12'h010, 12'h010, 72'h010008000000010000, 72'h010008000000010000);
        flt(8'h3A, 12'h010, 12'h000, 72'h010000010000000000, 72'h008000000000000000);
        flt(8'h12, 12'h040, 12'h040, 72'h010008000000040000, 72'h004000000000040000);
        wr(`PF_ADDR_A0, 16'h0C00);
        rc(`PF_ADDR_A0, 16'h0400);
        flt(8'h1A, 12'h010, 12'h010, 72'hFF0008000000010000, 72'h004000000000010000);
        final_report();
    end
endmodule
`default_nettype wire
